//--- include/mqx_pkg.sv
// Package with constants and types for the multi-queue expansion and output control block.
package mqx_pkg;
    localparam int ADDR_W = 8;
    localparam int DEV_ID_W = 3;
    localparam int QUEUE_W = 5;
    localparam int QUEUE_COUNT = 16;
    localparam int SECTOR_W = 8;
    localparam int DATA_W = 36;
    localparam int OUT_PIPE_STAGES = 2;

    localparam int AVS_ADDR_W = 4;
    localparam int AVS_DATA_W = 32;

    // Word indices of the register map; byte address is four times the index.
    localparam logic [AVS_ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [AVS_ADDR_W-1:0] REG_WRITE_SEL = 4'h2;
    localparam logic [AVS_ADDR_W-1:0] REG_READ_SEL = 4'h3;

    localparam int CTRL_FLAG_EN_BIT = 0;
    localparam int CTRL_DIRECT_SECTOR_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int ST_ID_LSB = 0;
    localparam int ST_MASTER_BIT = 3;
    localparam int ST_POLLED_BIT = 4;
    localparam int ST_RD_SEL_BIT = 5;
    localparam int ST_WR_SEL_BIT = 6;
    localparam int ST_IN_W_LSB = 8;
    localparam int ST_OUT_W_LSB = 10;
    localparam int ST_FLAG_STATE_LSB = 12;
    localparam int ST_WIDTH_BAD_BIT = 15;

    localparam int SEL_VALID_BIT = 8;

    // Port width codes.
    typedef enum logic [1:0] {
        MQX_W36 = 2'h0,
        MQX_W18 = 2'h1,
        MQX_W9 = 2'h2
    } mqx_width_t;

    localparam int W18_BITS = 18;
    localparam int W9_BITS = 9;

    typedef enum logic [1:0] {
        MQX_FS_IDLE,
        MQX_FS_SECTOR1,
        MQX_FS_SECTOR2
    } mqx_flag_state_t;
endpackage

//--- rtl/mqx_expansion_ctrl.sv
// Expansion, device selection, flag bus token chain and output control of a multi-queue device.
`timescale 1ns/100ps

module mqx_expansion_ctrl
    import mqx_pkg::*;
#(
    parameter int DWIDTH = DATA_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [DEV_ID_W-1:0] CHAIN_IDENTITY_PINS,
    input wire logic MASTER_SELECT,
    input wire logic INPUT_WIDTH_STRAP,
    input wire logic OUTPUT_WIDTH_STRAP,
    input wire logic BUS_MATCHING_STRAP,
    input wire logic FLAG_MODE_POLLED,
    input wire logic [ADDR_W-1:0] WRITE_QUEUE_ADDRESS,
    input wire logic WRITE_ADDRESS_ENABLE,
    input wire logic [ADDR_W-1:0] READ_QUEUE_ADDRESS,
    input wire logic READ_ADDRESS_ENABLE,
    output logic WRITE_SELECTED,
    output logic [QUEUE_W-1:0] WRITE_QUEUE,
    output logic READ_SELECTED,
    output logic [QUEUE_W-1:0] READ_QUEUE,
    input wire logic [QUEUE_COUNT-1:0] QUEUE_ALMOST_FULL_N,
    input wire logic FLAG_TOKEN_IN,
    output logic FLAG_TOKEN_OUT,
    output logic FLAG_SECTOR_SYNC,
    output logic [SECTOR_W-1:0] ALMOST_FULL_FLAG_BUS_O,
    output logic ALMOST_FULL_FLAG_BUS_OE,
    input wire logic [DWIDTH-1:0] READ_DATA_IN,
    input wire logic READ_WORD_AVAILABLE,
    input wire logic OUTPUT_ENABLE_N,
    output logic [DWIDTH-1:0] DATA_OUT_O,
    output logic DATA_OUT_OE,
    output logic OUTPUT_VALID_N_O,
    output logic OUTPUT_VALID_N_OE,
    output logic [1:0] INPUT_WIDTH,
    output logic [1:0] OUTPUT_WIDTH,
    input wire logic [AVS_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [AVS_DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [AVS_DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    // Upper address bits name the device, lower bits the queue.
    function automatic logic [DEV_ID_W-1:0] addr_device(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: DEV_ID_W];
    endfunction

    function automatic logic [QUEUE_W-1:0] addr_queue(input logic [ADDR_W-1:0] a);
        return a[QUEUE_W-1:0];
    endfunction

    // Width decode: bus matching off gives 36 in and out; otherwise the two
    // width straps choose which side is narrowed, so one side stays 36 wide.
    function automatic logic [3:0] width_decode(input logic bm, input logic iw,
                                                input logic ow);
        logic [3:0] r;
        r = {MQX_W36, MQX_W36};
        if (bm) begin
            unique case ({iw, ow})
                2'b00: r = {MQX_W36, MQX_W18};
                2'b01: r = {MQX_W36, MQX_W9};
                2'b10: r = {MQX_W18, MQX_W36};
                2'b11: r = {MQX_W9, MQX_W36};
            endcase
        end
        return r;
    endfunction

    function automatic logic [DWIDTH-1:0] width_mask(input logic [1:0] w);
        logic [DWIDTH-1:0] m;
        m = '1;
        if (w == MQX_W18) begin
            m = {{(DWIDTH-W18_BITS){1'b0}}, {W18_BITS{1'b1}}};
        end else if (w == MQX_W9) begin
            m = {{(DWIDTH-W9_BITS){1'b0}}, {W9_BITS{1'b1}}};
        end
        return m;
    endfunction

    logic capture_pending;
    logic [DEV_ID_W-1:0] device_id;
    logic is_master;
    logic polled_mode;
    logic [1:0] in_width;
    logic [1:0] out_width;
    logic [1:0] ctrl;
    logic write_selected;
    logic [QUEUE_W-1:0] write_queue;
    logic read_selected;
    logic [QUEUE_W-1:0] read_queue;
    mqx_flag_state_t flag_state;
    mqx_flag_state_t next_flag_state;
    logic [SECTOR_W-1:0] flag_bus;
    logic flag_bus_drive;
    logic next_flag_bus_drive;
    logic [SECTOR_W-1:0] next_flag_bus;
    logic avs_ack;
    logic [AVS_DATA_W-1:0] avs_rdata;
    logic [AVS_DATA_W-1:0] next_rdata;
    logic [DWIDTH-1:0] pipe_out_data;
    logic pipe_out_valid;
    logic [3:0] widths;

    // Straps are caught by the first clock edge after reset is released, since
    // an asynchronously reset flop may only load a constant.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            capture_pending <= 1'b1;
        end else begin
            capture_pending <= 1'b0;
        end
    end

    assign widths = width_decode(BUS_MATCHING_STRAP, INPUT_WIDTH_STRAP, OUTPUT_WIDTH_STRAP);

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            device_id <= '0;
            is_master <= 1'b0;
            polled_mode <= 1'b0;
            in_width <= MQX_W36;
            out_width <= MQX_W36;
        end else if (capture_pending) begin
            device_id <= CHAIN_IDENTITY_PINS;
            is_master <= MASTER_SELECT;
            polled_mode <= FLAG_MODE_POLLED;
            in_width <= widths[3:2];
            out_width <= widths[1:0];
        end
    end

    // Write port selection; a selection for another device deselects this one.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            write_selected <= 1'b0;
            write_queue <= '0;
        end else if (WRITE_ADDRESS_ENABLE && !capture_pending) begin
            write_selected <= (addr_device(WRITE_QUEUE_ADDRESS) == device_id);
            if (addr_device(WRITE_QUEUE_ADDRESS) == device_id) begin
                write_queue <= addr_queue(WRITE_QUEUE_ADDRESS);
            end
        end
    end

    // Read port selection. The master owns the read side from reset until some
    // selection names another device; a slave owns it only once it is named.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            read_selected <= 1'b0;
            read_queue <= '0;
        end else if (capture_pending) begin
            read_selected <= MASTER_SELECT;
        end else if (READ_ADDRESS_ENABLE) begin
            read_selected <= (addr_device(READ_QUEUE_ADDRESS) == device_id);
            if (addr_device(READ_QUEUE_ADDRESS) == device_id) begin
                read_queue <= addr_queue(READ_QUEUE_ADDRESS);
            end
        end
    end

    assign WRITE_SELECTED = write_selected;
    assign WRITE_QUEUE = write_queue;
    assign READ_SELECTED = read_selected;
    assign READ_QUEUE = read_queue;
    assign INPUT_WIDTH = in_width;
    assign OUTPUT_WIDTH = out_width;

    // Polled flag bus: each turn is two write-clock cycles, first sector then
    // second. The master opens the ring; others wait for the token.
    always_comb begin
        next_flag_state = flag_state;
        if (!polled_mode || !ctrl[CTRL_FLAG_EN_BIT]) begin
            next_flag_state = MQX_FS_IDLE;
        end else begin
            unique case (flag_state)
                MQX_FS_IDLE: begin
                    if (FLAG_TOKEN_IN) begin
                        next_flag_state = MQX_FS_SECTOR1;
                    end
                end
                MQX_FS_SECTOR1: next_flag_state = MQX_FS_SECTOR2;
                MQX_FS_SECTOR2: next_flag_state = MQX_FS_IDLE;
            endcase
        end
    end

    // A token arriving while this device still holds its turn restarts it at
    // the first sector; the ring carries one token so this only happens when
    // a single device loops its own token back.
    logic master_start;
    logic master_started;
    assign master_start = is_master && polled_mode && ctrl[CTRL_FLAG_EN_BIT] &&
                          !master_started;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            master_started <= 1'b0;
        end else if (!polled_mode || !ctrl[CTRL_FLAG_EN_BIT]) begin
            master_started <= 1'b0;
        end else if (master_start) begin
            master_started <= 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_state <= MQX_FS_IDLE;
        end else if (master_start) begin
            flag_state <= MQX_FS_SECTOR1;
        end else if (FLAG_TOKEN_IN && polled_mode && ctrl[CTRL_FLAG_EN_BIT]) begin
            flag_state <= MQX_FS_SECTOR1;
        end else begin
            flag_state <= next_flag_state;
        end
    end

    // Bus contents are loaded at the same edge as the state, so in polled mode
    // the sector on the bus always matches the sync level in that cycle.
    always_comb begin
        next_flag_bus = QUEUE_ALMOST_FULL_N[SECTOR_W-1:0];
        next_flag_bus_drive = 1'b0;
        if (polled_mode) begin
            if (master_start || (FLAG_TOKEN_IN && ctrl[CTRL_FLAG_EN_BIT])) begin
                next_flag_bus = QUEUE_ALMOST_FULL_N[SECTOR_W-1:0];
                next_flag_bus_drive = 1'b1;
            end else if (next_flag_state == MQX_FS_SECTOR2) begin
                next_flag_bus = QUEUE_ALMOST_FULL_N[QUEUE_COUNT-1:SECTOR_W];
                next_flag_bus_drive = 1'b1;
            end
        end else begin
            // Direct mode: the write-selected device shows the sector chosen
            // in the control register.
            if (ctrl[CTRL_DIRECT_SECTOR_BIT]) begin
                next_flag_bus = QUEUE_ALMOST_FULL_N[QUEUE_COUNT-1:SECTOR_W];
            end
            next_flag_bus_drive = ctrl[CTRL_FLAG_EN_BIT] && write_selected;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flag_bus <= '0;
            flag_bus_drive <= 1'b0;
        end else begin
            flag_bus <= next_flag_bus;
            flag_bus_drive <= next_flag_bus_drive;
        end
    end

    assign ALMOST_FULL_FLAG_BUS_O = flag_bus;
    assign ALMOST_FULL_FLAG_BUS_OE = flag_bus_drive;
    assign FLAG_SECTOR_SYNC = (flag_state == MQX_FS_SECTOR1);
    assign FLAG_TOKEN_OUT = (flag_state == MQX_FS_SECTOR2);

    // Output data path. A word counts as valid only while this device owns the
    // read side and the selected queue still holds data.
    mqx_out_pipe #(
        .WIDTH(DWIDTH),
        .STAGES(OUT_PIPE_STAGES)
    ) u_out_pipe (
        .clk(CLK),
        .resetn(RESETN),
        .in_data(READ_DATA_IN & width_mask(out_width)),
        .in_valid(READ_WORD_AVAILABLE && read_selected),
        .out_data(pipe_out_data),
        .out_valid(pipe_out_valid)
    );

    assign DATA_OUT_O = pipe_out_data;
    assign OUTPUT_VALID_N_O = !pipe_out_valid;
    assign OUTPUT_VALID_N_OE = read_selected;
    // The enable is not registered: the pin gates the drivers directly.
    assign DATA_OUT_OE = read_selected && !OUTPUT_ENABLE_N;

    // Avalon-MM slave: every access holds waitrequest for one cycle, then
    // completes; read data is registered at the first edge of the request.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            avs_ack <= 1'b0;
        end else begin
            avs_ack <= (AVS_READ || AVS_WRITE) && !avs_ack;
        end
    end

    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !avs_ack;

    always_comb begin
        next_rdata = '0;
        unique case (AVS_ADDRESS)
            REG_CTRL: next_rdata[1:0] = ctrl;
            REG_STATUS: begin
                next_rdata[ST_ID_LSB +: DEV_ID_W] = device_id;
                next_rdata[ST_MASTER_BIT] = is_master;
                next_rdata[ST_POLLED_BIT] = polled_mode;
                next_rdata[ST_RD_SEL_BIT] = read_selected;
                next_rdata[ST_WR_SEL_BIT] = write_selected;
                next_rdata[ST_IN_W_LSB +: 2] = in_width;
                next_rdata[ST_OUT_W_LSB +: 2] = out_width;
                next_rdata[ST_FLAG_STATE_LSB +: 2] = flag_state;
            end
            REG_WRITE_SEL: begin
                next_rdata[QUEUE_W-1:0] = write_queue;
                next_rdata[SEL_VALID_BIT] = write_selected;
            end
            REG_READ_SEL: begin
                next_rdata[QUEUE_W-1:0] = read_queue;
                next_rdata[SEL_VALID_BIT] = read_selected;
            end
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            avs_rdata <= '0;
        end else if (AVS_READ && !avs_ack) begin
            avs_rdata <= next_rdata;
        end
    end

    assign AVS_READDATA = avs_rdata;

    // Control writes land at the edge where waitrequest is seen low.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl <= CTRL_RESET;
        end else if (AVS_WRITE && avs_ack && AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
            ctrl <= AVS_WRITEDATA[1:0];
        end
    end
endmodule

//--- rtl/mqx_out_pipe.sv
// Output data path pipeline carrying the data word and its valid mark together.
`timescale 1ns/100ps
module mqx_out_pipe
    import mqx_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int STAGES = OUT_PIPE_STAGES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid
);
    logic [WIDTH-1:0] data_stage [STAGES];
    logic [STAGES-1:0] valid_stage;

    // The valid mark travels in step with the data so that it always describes
    // the word currently presented at the end of the pipe.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < STAGES; i++) begin
                data_stage[i] <= '0;
            end
            valid_stage <= '0;
        end else begin
            data_stage[0] <= in_data;
            valid_stage[0] <= in_valid;
            for (int i = 1; i < STAGES; i++) begin
                data_stage[i] <= data_stage[i-1];
                valid_stage[i] <= valid_stage[i-1];
            end
        end
    end

    assign out_data = data_stage[STAGES-1];
    assign out_valid = valid_stage[STAGES-1];
endmodule

//--- sim/mqx_chain_peer.sv
// Behavioural model of the neighbouring device on the polled flag bus ring.
`timescale 1ns/100ps
module mqx_chain_peer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic token_in,
    input wire logic [3:0] gap,
    output logic token_out
);
    logic [4:0] cnt;
    // Gap idle cycles, then its own two sectors; the token leaves in its second sector cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 5'h00;
            token_out <= 1'b0;
        end else begin
            token_out <= (cnt == 5'h01);
            if (token_in) begin
                cnt <= {1'b0, gap} + 5'h01;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

//--- sim/mqx_expansion_ctrl_asserts.sv
// Concurrent checks on the ports of the multi-queue expansion block.
`timescale 1ns/100ps
module mqx_expansion_ctrl_asserts
    import mqx_pkg::*;
#(
    parameter int DWIDTH = DATA_W
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [DEV_ID_W-1:0] CHAIN_IDENTITY_PINS,
    input wire logic MASTER_SELECT,
    input wire logic [ADDR_W-1:0] WRITE_QUEUE_ADDRESS,
    input wire logic WRITE_ADDRESS_ENABLE,
    input wire logic [ADDR_W-1:0] READ_QUEUE_ADDRESS,
    input wire logic READ_ADDRESS_ENABLE,
    input wire logic WRITE_SELECTED,
    input wire logic [QUEUE_W-1:0] WRITE_QUEUE,
    input wire logic READ_SELECTED,
    input wire logic FLAG_TOKEN_OUT,
    input wire logic FLAG_SECTOR_SYNC,
    input wire logic ALMOST_FULL_FLAG_BUS_OE,
    input wire logic [DWIDTH-1:0] READ_DATA_IN,
    input wire logic READ_WORD_AVAILABLE,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic [DWIDTH-1:0] DATA_OUT_O,
    input wire logic DATA_OUT_OE,
    input wire logic OUTPUT_VALID_N_O,
    input wire logic OUTPUT_VALID_N_OE,
    input wire logic [1:0] INPUT_WIDTH,
    input wire logic [1:0] OUTPUT_WIDTH
);
    logic first;
    logic in_ok;
    logic [DEV_ID_W-1:0] id;
    assign in_ok = READ_WORD_AVAILABLE & READ_SELECTED;
    // The identity is latched here too, so later strap movement cannot hide a compare fault.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            first <= 1'b1;
            id <= '0;
        end else if (first) begin
            first <= 1'b0;
            id <= CHAIN_IDENTITY_PINS;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // The release edge still sees reset low, so only the following edge captures.
    role_capture_a: assert property (first && RESETN |=> READ_SELECTED == $past(MASTER_SELECT))
        else $error("read ownership does not follow master select");
    wr_select_a: assert property (!first && WRITE_ADDRESS_ENABLE |=>
        WRITE_SELECTED == ($past(WRITE_QUEUE_ADDRESS[7:5]) == id))
        else $error("write selection compare wrong");
    wr_queue_a: assert property (!first && WRITE_ADDRESS_ENABLE &&
        WRITE_QUEUE_ADDRESS[7:5] == id |=> WRITE_QUEUE == $past(WRITE_QUEUE_ADDRESS[4:0]))
        else $error("write queue field wrong");
    rd_select_a: assert property (!first && READ_ADDRESS_ENABLE |=>
        READ_SELECTED == ($past(READ_QUEUE_ADDRESS[7:5]) == id))
        else $error("read selection compare wrong");
    token_pulse_a: assert property (FLAG_TOKEN_OUT |->
        (ALMOST_FULL_FLAG_BUS_OE && !FLAG_SECTOR_SYNC) ##1 !FLAG_TOKEN_OUT)
        else $error("token pulse not with second sector");
    sector_order_a: assert property (FLAG_SECTOR_SYNC |->
        ALMOST_FULL_FLAG_BUS_OE ##1 (FLAG_TOKEN_OUT && !FLAG_SECTOR_SYNC))
        else $error("sector sync order wrong");
    data_oe_a: assert property (DATA_OUT_OE == (READ_SELECTED && !OUTPUT_ENABLE_N))
        else $error("data output enable wrong");
    ov_float_a: assert property (OUTPUT_VALID_N_OE == READ_SELECTED)
        else $error("valid flag enable wrong");
    ov_pipe_a: assert property (OUTPUT_VALID_N_O == !$past(in_ok, 2))
        else $error("valid flag not two cycles behind");
    ov_data_a: assert property (!OUTPUT_VALID_N_O && OUTPUT_WIDTH == MQX_W36 |->
        DATA_OUT_O == $past(READ_DATA_IN, 2))
        else $error("output word does not match valid flag");
    width_pair_a: assert property (INPUT_WIDTH != 2'h3 && OUTPUT_WIDTH != 2'h3 &&
        (INPUT_WIDTH == MQX_W36 || OUTPUT_WIDTH == MQX_W36))
        else $error("width pair illegal");
endmodule

bind mqx_expansion_ctrl mqx_expansion_ctrl_asserts #(.DWIDTH(DWIDTH))
    mqx_expansion_ctrl_asserts_i (.*);

//--- sim/mqx_expansion_ctrl_bench.sv
// Self-checking bench for the multi-queue expansion and output control block.
`timescale 1ns/100ps
module mqx_expansion_ctrl_bench
    import mqx_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic s; logic [4:0] q;} mqx_row_t;
    logic CLK, RESETN, MASTER_SELECT, INPUT_WIDTH_STRAP, OUTPUT_WIDTH_STRAP, BUS_MATCHING_STRAP;
    logic FLAG_MODE_POLLED, WRITE_ADDRESS_ENABLE, READ_ADDRESS_ENABLE, READ_WORD_AVAILABLE;
    logic OUTPUT_ENABLE_N, AVS_READ, AVS_WRITE, FLAG_TOKEN_IN, FLAG_TOKEN_OUT, FLAG_SECTOR_SYNC;
    logic WRITE_SELECTED, READ_SELECTED, ALMOST_FULL_FLAG_BUS_OE, DATA_OUT_OE;
    logic OUTPUT_VALID_N_O, OUTPUT_VALID_N_OE, AVS_WAITREQUEST;
    logic [2:0] CHAIN_IDENTITY_PINS;
    logic [7:0] WRITE_QUEUE_ADDRESS, READ_QUEUE_ADDRESS, ALMOST_FULL_FLAG_BUS_O;
    logic [4:0] WRITE_QUEUE, READ_QUEUE;
    logic [15:0] QUEUE_ALMOST_FULL_N;
    logic [35:0] READ_DATA_IN, DATA_OUT_O;
    logic [1:0] INPUT_WIDTH, OUTPUT_WIDTH;
    logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE, peer_gap;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdata;
    int n_mismatch, n_tests, n;
    mqx_row_t rows [5] = '{'{8'hA3, 1'b1, 5'h03}, '{8'hBF, 1'b1, 5'h1F}, '{8'h3C, 1'b0, 5'h1F},
        '{8'hE0, 1'b0, 5'h1F}, '{8'hA0, 1'b1, 5'h00}};

    mqx_expansion_ctrl mqx_expansion_ctrl_i (.*);
    mqx_chain_peer mqx_chain_peer_i (.clk(CLK), .resetn(RESETN), .token_in(FLAG_TOKEN_OUT),
        .gap(peer_gap), .token_out(FLAG_TOKEN_IN));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Straps are set up while reset is low and only then is reset released.
    task automatic do_reset(input logic ms, input logic [2:0] id, input logic pol);
        RESETN <= 1'b0;
        MASTER_SELECT <= ms;
        CHAIN_IDENTITY_PINS <= id;
        FLAG_MODE_POLLED <= pol;
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
    endtask

    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        n = 0;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0);
        rdata = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        chk("avs cycles", n, 2);
    endtask

    task automatic sel(input logic rd, input logic [7:0] a);
        @(posedge CLK);
        if (rd) begin
            READ_QUEUE_ADDRESS <= a;
            READ_ADDRESS_ENABLE <= 1'b1;
        end else begin
            WRITE_QUEUE_ADDRESS <= a;
            WRITE_ADDRESS_ENABLE <= 1'b1;
        end
        @(posedge CLK);
        READ_ADDRESS_ENABLE <= 1'b0;
        WRITE_ADDRESS_ENABLE <= 1'b0;
        #1;
    endtask

    initial begin
        {RESETN, MASTER_SELECT, FLAG_MODE_POLLED, CHAIN_IDENTITY_PINS} = '0;
        {INPUT_WIDTH_STRAP, OUTPUT_WIDTH_STRAP, BUS_MATCHING_STRAP} = '0;
        {WRITE_ADDRESS_ENABLE, READ_ADDRESS_ENABLE, READ_WORD_AVAILABLE, OUTPUT_ENABLE_N} = '0;
        {WRITE_QUEUE_ADDRESS, READ_QUEUE_ADDRESS, READ_DATA_IN, AVS_ADDRESS} = '0;
        {AVS_READ, AVS_WRITE, AVS_WRITEDATA, peer_gap} = '0;
        QUEUE_ALMOST_FULL_N = 16'h5AC3;
        AVS_BYTEENABLE = 4'hF;
        do_reset(1'b1, 3'h5, 1'b1);
        chk("read owner", READ_SELECTED, 1'b1);
        chk("master drives", DATA_OUT_OE, 1'b1);
        chk("widths", {INPUT_WIDTH, OUTPUT_WIDTH}, 4'h0);
        $display("done: reset");
        av(1'b1, REG_CTRL, 32'h00000001);
        av(1'b0, REG_CTRL, 32'h00000000);
        chk("ctrl", rdata[1:0], 2'h1);
        av(1'b0, REG_STATUS, 32'h00000000);
        chk("status", rdata[4:0], 5'h1D);
        av(1'b0, 4'hF, 32'h00000000);
        chk("unmapped", rdata, 32'h00000000);
        $display("done: registers");
        for (int r = 0; r < 2; r++) begin
            peer_gap <= 4'(r * 5);
            n = 0;
            do begin
                @(posedge CLK);
                n++;
            end while (FLAG_TOKEN_IN !== 1'b1 && n < 100);
            #1;
            chk("token back", n < 100, 1'b1);
            chk("sync one", FLAG_SECTOR_SYNC, 1'b1);
            chk("bus oe", ALMOST_FULL_FLAG_BUS_OE, 1'b1);
            chk("sector one", ALMOST_FULL_FLAG_BUS_O, QUEUE_ALMOST_FULL_N[7:0]);
            @(posedge CLK);
            #1;
            chk("token out", FLAG_TOKEN_OUT, 1'b1);
            chk("sync two", FLAG_SECTOR_SYNC, 1'b0);
            chk("sector two", ALMOST_FULL_FLAG_BUS_O, QUEUE_ALMOST_FULL_N[15:8]);
            @(posedge CLK);
            #1;
            chk("bus release", ALMOST_FULL_FLAG_BUS_OE, 1'b0);
        end
        $display("done: token ring");
        foreach (rows[i]) begin
            for (int rd = 0; rd < 2; rd++) begin
                sel(rd[0], rows[i].a);
                chk("selected", rd ? READ_SELECTED : WRITE_SELECTED, rows[i].s);
                chk("queue", rd ? READ_QUEUE : WRITE_QUEUE, rows[i].q);
                if (rd) chk("data oe", DATA_OUT_OE, rows[i].s);
            end
        end
        $display("done: selection");
        @(posedge CLK);
        READ_DATA_IN <= 36'h9ABCD1234;
        READ_WORD_AVAILABLE <= 1'b1;
        @(posedge CLK);
        #1;
        chk("valid early", OUTPUT_VALID_N_O, 1'b1);
        @(posedge CLK);
        #1;
        chk("valid", OUTPUT_VALID_N_O, 1'b0);
        chk("word", DATA_OUT_O, 36'h9ABCD1234);
        @(posedge CLK);
        READ_WORD_AVAILABLE <= 1'b0;
        OUTPUT_ENABLE_N <= 1'b1;
        #1;
        chk("async float", DATA_OUT_OE, 1'b0);
        @(posedge CLK);
        #1;
        chk("last word", OUTPUT_VALID_N_O, 1'b0);
        @(posedge CLK);
        OUTPUT_ENABLE_N <= 1'b0;
        #1;
        chk("empty", OUTPUT_VALID_N_O, 1'b1);
        $display("done: output valid");
        @(posedge CLK);
        do_reset(1'b0, 3'h2, 1'b0);
        chk("slave owner", READ_SELECTED, 1'b0);
        chk("slave float", DATA_OUT_OE, 1'b0);
        chk("valid float", OUTPUT_VALID_N_OE, 1'b0);
        @(posedge CLK);
        CHAIN_IDENTITY_PINS <= 3'h7;
        sel(1'b1, 8'h45);
        chk("slave picked", READ_SELECTED, 1'b1);
        chk("slave drives", DATA_OUT_OE, 1'b1);
        chk("slave queue", READ_QUEUE, 5'h05);
        $display("done: slave");
        @(posedge CLK);
        {BUS_MATCHING_STRAP, INPUT_WIDTH_STRAP, OUTPUT_WIDTH_STRAP} <= 3'b101;
        do_reset(1'b1, 3'h0, 1'b0);
        chk("single owner", READ_SELECTED, 1'b1);
        chk("narrow widths", {INPUT_WIDTH, OUTPUT_WIDTH}, 4'h2);
        sel(1'b1, 8'h07);
        chk("single queue", READ_QUEUE, 5'h07);
        @(posedge CLK);
        READ_WORD_AVAILABLE <= 1'b1;
        repeat (2) @(posedge CLK);
        #1;
        chk("narrow valid", OUTPUT_VALID_N_O, 1'b0);
        chk("narrow word", DATA_OUT_O, 36'h000000034);
        $display("done: single");
        tally_and_finish();
    end

    // Fewer than two hundred cycles are expected; this allows for about twenty thousand.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
